//--- hw/rlcr_cfg.svh
// rlcr_cfg.svh: addresses, field positions, reset values and decode codes
// for the per-lane configuration register slice. assumes 8-bit management register addressing.
`ifndef RLCR_CFG_SVH
`define RLCR_CFG_SVH

// ==========================================
// register offsets
`define RLCR_OFS_L5_DEEMPH  8'h35
`define RLCR_OFS_L5_IDLETH  8'h36
`define RLCR_OFS_L6_IDLERT  8'h39
`define RLCR_OFS_L6_EQ      8'h3A
`define RLCR_OFS_L6_SWING   8'h3B

// ==========================================
// reset values
`define RLCR_RST_L5_DEEMPH  8'h03
`define RLCR_RST_L5_IDLETH  8'h00
`define RLCR_RST_L6_IDLERT  8'h00
`define RLCR_RST_L6_EQ      8'h20
`define RLCR_RST_L6_SWING   8'h03

// ==========================================
// field positions and writable masks
`define RLCR_DE_STYLE_BIT   7
`define RLCR_TH_DEASSERT_HI 3
`define RLCR_TH_DEASSERT_LO 2
`define RLCR_TH_ASSERT_HI   1
`define RLCR_TH_ASSERT_LO   0
`define RLCR_IR_IDLE_AUTO   5
`define RLCR_IR_IDLE_SEL    4
`define RLCR_IR_RATE_AUTO   1
`define RLCR_IR_RATE_SEL    0
`define RLCR_EQ_EN_BIT      5
`define RLCR_EQ_GST_HI      4
`define RLCR_EQ_GST_LO      3
`define RLCR_EQ_BST_HI      2
`define RLCR_EQ_BST_LO      0
`define RLCR_MSK_IDLETH     8'h0F
`define RLCR_MSK_IDLERT     8'h33
`define RLCR_MSK_EQ         8'h3F
`define RLCR_MSK_SWING      8'h3F

// ==========================================
// de-emphasis codes (style bit plus level)
`define RLCR_DE_0P0         8'h01
`define RLCR_DE_3P5         8'h38
`define RLCR_DE_6P0         8'h88
`define RLCR_DE_9P0         8'h90
`define RLCR_DE_12P0        8'hA0
`define RLCR_DE_RSVD        8'hC0

// ==========================================
// equalizer codes
`define RLCR_EQ_BYPASS      6'h20
`define RLCR_EQ_2A          6'h2A
`define RLCR_EQ_30          6'h30
`define RLCR_EQ_31          6'h31
`define RLCR_EQ_38          6'h38
`define RLCR_EQ_34          6'h34
`define RLCR_EQ_35          6'h35
`define RLCR_EQ_3A          6'h3A
`define RLCR_EQ_3C          6'h3C
`define RLCR_EQ_GST_MAX     2'h2

// ==========================================
// output swing codes
`define RLCR_SW_600         6'h03
`define RLCR_SW_800         6'h07
`define RLCR_SW_1000        6'h0F
`define RLCR_SW_1200        6'h1F
`define RLCR_SW_1400        6'h3F

`endif

//--- hw/rlcr_pkg.sv
// rlcr_pkg.sv: types shared by the lane configuration register slice.
// assumes rlcr_cfg.svh provides the numeric constants.
package rlcr_pkg;

	// ==========================================
	// three-level pin strap
	typedef enum logic [2:0] {
		RLCR_PIN_LOW   = 3'b001,
		RLCR_PIN_HIGH  = 3'b010,
		RLCR_PIN_FLOAT = 3'b100
	} rlcr_pin_e;

	// ==========================================
	// idle threshold pairs (de-assert/assert)
	typedef enum logic [1:0] {
		RLCR_TH_110_70  = 2'h0,
		RLCR_TH_150_110 = 2'h1,
		RLCR_TH_170_130 = 2'h2,
		RLCR_TH_190_150 = 2'h3
	} rlcr_thresh_e;

	// ==========================================
	// manual rate ranges
	typedef enum logic {
		RLCR_RATE_LOW  = 1'b0,
		RLCR_RATE_HIGH = 1'b1
	} rlcr_rate_e;

	typedef logic [7:0] rlcr_byte_t;

endpackage

//--- hw/rlcr_lane_regs.sv
// rlcr_lane_regs.sv: lane 5 de-emphasis/idle threshold and lane 6 idle-rate,
// equalizer and output swing registers, plus pin strap decode to the same codes.
// assumes the management serial front end delivers decoded byte reads/writes on
// this clock; strap pins are asynchronous and are synchronised here.
// Summary of operation
// RL1 - de-emphasis byte bit 7 picks style: 0 compatibility, 1 enhanced
// RL2 - de-emphasis bits 6:0 carry the level code to the driver
// RL3 - de-emphasis codes 01,38,88,90,A0 give 0 to -12 dB; C0 reserved
// RL4 - de-emphasis straps map to register codes; all-float is reserved
// RL5 - idle threshold bits 3:2 de-assert, bits 1:0 assert
// RL6 - threshold codes 00..11 give 110/70 up to 190/150 mV, default 00
// RL7 - idle-auto bit 5 picks auto detection, else bit 4 governs muting
// RL8 - manual idle select 0 keeps output on, 1 mutes to electrical idle
// RL9 - rate-auto bit 1 enables auto rate, else bit 0 selects range
// RL10 - manual rate 0 gives 2.5-3.2 Gbps, 1 gives 5.0-6.4 Gbps
// RL11 - equalizer bit 5 enable, bits 4:3 gain stage, bits 2:0 boost
// RL12 - equalizer has 24 levels: three gain stages of eight boosts
// RL13 - equalizer straps map to codes; all-float gives bypass 20h
// RL14 - swing codes 03,07,0F,1F,3F give 600 to 1400 mV, default 03
// RL15 - host writes zero to reserved bits and ignores their read value
`include "rlcr_cfg.svh"

module rlcr_lane_regs #(
	parameter int ADDR_W = 8
) (
	// clock, reset, enable
	input  wire logic                clock,
	input  wire logic                nrst,
	input  wire logic                clk_en,
	// management register access
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic                reg_wr,
	input  wire logic [7:0]          reg_wdata,
	input  wire logic                reg_rd,
	output logic      [7:0]          reg_rdata,
	output logic                     reg_hit,
	// pin straps, three-level each, and strap mode select
	input  wire logic                strap_mode,
	input  wire rlcr_pkg::rlcr_pin_e deemph_strap_hi,
	input  wire rlcr_pkg::rlcr_pin_e deemph_strap_lo,
	input  wire rlcr_pkg::rlcr_pin_e equalizer_strap_a,
	input  wire rlcr_pkg::rlcr_pin_e equalizer_strap_b,
	// lane 5 driver settings
	output logic                     lane5_deemphasis_style,
	output logic      [6:0]          lane5_deemphasis_level,
	output logic                     lane5_deemph_reserved,
	output logic      [1:0]          lane5_idle_deassert_th,
	output logic      [1:0]          lane5_idle_assert_th,
	// lane 6 idle and rate control
	output logic                     lane6_idle_auto,
	output logic                     lane6_output_muted,
	output logic                     lane6_signal_detect_en,
	output logic                     lane6_rate_auto,
	output logic                     lane6_rate_high,
	// lane 6 equalizer and swing
	output logic                     lane6_eq_enable,
	output logic      [1:0]          lane6_gain_stage_field,
	output logic      [2:0]          lane6_boost_step_field,
	output logic                     lane6_eq_level_valid,
	output logic      [4:0]          lane6_eq_level_index,
	output logic      [5:0]          lane6_swing_field,
	output logic                     lane6_swing_valid
);

	// ==========================================
	// elaboration checks
	if (ADDR_W < 6) begin : g_chk
		$error("rlcr_lane_regs: ADDR_W too small for the register offsets");
	end

	// ==========================================
	// functions
	function automatic logic [7:0] deemph_map(input rlcr_pkg::rlcr_pin_e hi,
	                                          input rlcr_pkg::rlcr_pin_e lo);
		logic [7:0] c;
		c = `RLCR_DE_RSVD;
		unique case ({hi, lo})
			{rlcr_pkg::RLCR_PIN_LOW,   rlcr_pkg::RLCR_PIN_LOW}:   c = `RLCR_DE_0P0;
			{rlcr_pkg::RLCR_PIN_LOW,   rlcr_pkg::RLCR_PIN_HIGH}:  c = `RLCR_DE_3P5;
			{rlcr_pkg::RLCR_PIN_LOW,   rlcr_pkg::RLCR_PIN_FLOAT}: c = `RLCR_DE_6P0;
			{rlcr_pkg::RLCR_PIN_HIGH,  rlcr_pkg::RLCR_PIN_FLOAT}: c = `RLCR_DE_12P0;
			{rlcr_pkg::RLCR_PIN_FLOAT, rlcr_pkg::RLCR_PIN_LOW}:   c = `RLCR_DE_9P0;
			{rlcr_pkg::RLCR_PIN_FLOAT, rlcr_pkg::RLCR_PIN_HIGH}:  c = `RLCR_DE_12P0;
			{rlcr_pkg::RLCR_PIN_HIGH,  rlcr_pkg::RLCR_PIN_LOW}:   c = `RLCR_DE_9P0;
			{rlcr_pkg::RLCR_PIN_HIGH,  rlcr_pkg::RLCR_PIN_HIGH}:  c = `RLCR_DE_12P0;
			default:                                              c = `RLCR_DE_RSVD;
		endcase
		return c; // [RL4]
	endfunction

	function automatic logic [5:0] eq_map(input rlcr_pkg::rlcr_pin_e a,
	                                      input rlcr_pkg::rlcr_pin_e b);
		logic [5:0] c;
		c = `RLCR_EQ_BYPASS;
		unique case ({a, b})
			{rlcr_pkg::RLCR_PIN_HIGH,  rlcr_pkg::RLCR_PIN_HIGH}:  c = `RLCR_EQ_2A;
			{rlcr_pkg::RLCR_PIN_LOW,   rlcr_pkg::RLCR_PIN_LOW}:   c = `RLCR_EQ_30;
			{rlcr_pkg::RLCR_PIN_LOW,   rlcr_pkg::RLCR_PIN_FLOAT}: c = `RLCR_EQ_31;
			{rlcr_pkg::RLCR_PIN_LOW,   rlcr_pkg::RLCR_PIN_HIGH}:  c = `RLCR_EQ_38;
			{rlcr_pkg::RLCR_PIN_HIGH,  rlcr_pkg::RLCR_PIN_FLOAT}: c = `RLCR_EQ_34;
			{rlcr_pkg::RLCR_PIN_HIGH,  rlcr_pkg::RLCR_PIN_LOW}:   c = `RLCR_EQ_35;
			{rlcr_pkg::RLCR_PIN_FLOAT, rlcr_pkg::RLCR_PIN_LOW}:   c = `RLCR_EQ_3A;
			{rlcr_pkg::RLCR_PIN_FLOAT, rlcr_pkg::RLCR_PIN_HIGH}:  c = `RLCR_EQ_3C;
			default:                                              c = `RLCR_EQ_BYPASS;
		endcase
		return c; // [RL13]
	endfunction

	// swing codes are a thermometer of ones from bit 0, at least two ones
	function automatic logic swing_ok(input logic [5:0] v);
		return (v == `RLCR_SW_600) || (v == `RLCR_SW_800) || (v == `RLCR_SW_1000) ||
		       (v == `RLCR_SW_1200) || (v == `RLCR_SW_1400); // [RL14]
	endfunction

	// ==========================================
	// strap synchronisers
	logic [11:0] strap_s1_r;
	logic [11:0] strap_s2_r;
	logic        mode_s1_r;
	logic        mode_s2_r;
	logic        mode_d_r;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			strap_s1_r <= {4{3'b100}};
			strap_s2_r <= {4{3'b100}};
			mode_s1_r  <= 1'b0;
			mode_s2_r  <= 1'b0;
			mode_d_r   <= 1'b0;
		end else if (clk_en) begin
			strap_s1_r <= {deemph_strap_hi, deemph_strap_lo, equalizer_strap_a,
			               equalizer_strap_b};
			strap_s2_r <= strap_s1_r;
			mode_s1_r  <= strap_mode;
			mode_s2_r  <= mode_s1_r;
			mode_d_r   <= mode_s2_r;
		end
	end

	// strap codes are loaded on the rising edge of strap mode and then
	// held, so a later register write still takes effect
	logic strap_load;
	assign strap_load = mode_s2_r && !mode_d_r;

	// ==========================================
	// register storage
	logic [7:0] l5_deemph_r;
	logic [7:0] l5_idleth_r;
	logic [7:0] l6_idlert_r;
	logic [7:0] l6_eq_r;
	logic [7:0] l6_swing_r;
	logic       wr_en;

	assign wr_en = clk_en && reg_wr;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			l5_deemph_r <= `RLCR_RST_L5_DEEMPH;
		end else if (clk_en && strap_load) begin
			l5_deemph_r <= deemph_map(rlcr_pkg::rlcr_pin_e'(strap_s2_r[11:9]),
			                          rlcr_pkg::rlcr_pin_e'(strap_s2_r[8:6])); // [RL4]
		end else if (wr_en && reg_addr == ADDR_W'(`RLCR_OFS_L5_DEEMPH)) begin
			l5_deemph_r <= reg_wdata; // [RL1] [RL2]
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			l5_idleth_r <= `RLCR_RST_L5_IDLETH; // [RL6]
		end else if (wr_en && reg_addr == ADDR_W'(`RLCR_OFS_L5_IDLETH)) begin
			l5_idleth_r <= reg_wdata & `RLCR_MSK_IDLETH;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			l6_idlert_r <= `RLCR_RST_L6_IDLERT;
		end else if (wr_en && reg_addr == ADDR_W'(`RLCR_OFS_L6_IDLERT)) begin
			l6_idlert_r <= reg_wdata & `RLCR_MSK_IDLERT;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			l6_eq_r <= `RLCR_RST_L6_EQ;
		end else if (clk_en && strap_load) begin
			l6_eq_r <= {2'h0, eq_map(rlcr_pkg::rlcr_pin_e'(strap_s2_r[5:3]),
			                         rlcr_pkg::rlcr_pin_e'(strap_s2_r[2:0]))}; // [RL13]
		end else if (wr_en && reg_addr == ADDR_W'(`RLCR_OFS_L6_EQ)) begin
			l6_eq_r <= reg_wdata & `RLCR_MSK_EQ;
		end
	end

	// bits 7:6 are read-only zero; only the swing field is writable
	always_ff @(posedge clock) begin
		if (!nrst) begin
			l6_swing_r <= `RLCR_RST_L6_SWING; // [RL14]
		end else if (wr_en && reg_addr == ADDR_W'(`RLCR_OFS_L6_SWING)) begin
			l6_swing_r <= reg_wdata & `RLCR_MSK_SWING;
		end
	end

	// ==========================================
	// read port, registered; reserved bits were masked at write
	always_ff @(posedge clock) begin
		if (!nrst) begin
			reg_rdata <= 8'h00;
			reg_hit   <= 1'b0;
		end else if (clk_en && reg_rd) begin
			reg_hit <= 1'b1;
			unique case (reg_addr)
				ADDR_W'(`RLCR_OFS_L5_DEEMPH): reg_rdata <= l5_deemph_r;
				ADDR_W'(`RLCR_OFS_L5_IDLETH): reg_rdata <= l5_idleth_r;
				ADDR_W'(`RLCR_OFS_L6_IDLERT): reg_rdata <= l6_idlert_r;
				ADDR_W'(`RLCR_OFS_L6_EQ):     reg_rdata <= l6_eq_r;
				ADDR_W'(`RLCR_OFS_L6_SWING):  reg_rdata <= l6_swing_r;
				default: begin
					reg_rdata <= 8'h00;
					reg_hit   <= 1'b0;
				end
			endcase
		end else if (clk_en) begin
			reg_hit <= 1'b0;
		end
	end

	// ==========================================
	// settings presented to the analog side
	logic [1:0] gain_stage_field;
	logic [2:0] boost_step_field;
	assign gain_stage_field = l6_eq_r[`RLCR_EQ_GST_HI:`RLCR_EQ_GST_LO];
	assign boost_step_field = l6_eq_r[`RLCR_EQ_BST_HI:`RLCR_EQ_BST_LO];

	always_ff @(posedge clock) begin
		if (!nrst) begin
			lane5_deemphasis_style <= 1'b0;
			lane5_deemphasis_level <= 7'h03;
			lane5_deemph_reserved  <= 1'b0;
			lane5_idle_deassert_th <= 2'h0;
			lane5_idle_assert_th   <= 2'h0;
		end else if (clk_en) begin
			lane5_deemphasis_style <= l5_deemph_r[`RLCR_DE_STYLE_BIT]; // [RL1]
			lane5_deemphasis_level <= l5_deemph_r[6:0]; // [RL2]
			lane5_deemph_reserved  <= (l5_deemph_r == `RLCR_DE_RSVD); // [RL3]
			lane5_idle_deassert_th <=
				l5_idleth_r[`RLCR_TH_DEASSERT_HI:`RLCR_TH_DEASSERT_LO]; // [RL5] [RL6]
			lane5_idle_assert_th   <=
				l5_idleth_r[`RLCR_TH_ASSERT_HI:`RLCR_TH_ASSERT_LO]; // [RL5] [RL6]
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			lane6_idle_auto        <= 1'b0;
			lane6_output_muted     <= 1'b0;
			lane6_signal_detect_en <= 1'b0;
			lane6_rate_auto        <= 1'b0;
			lane6_rate_high        <= 1'b0;
		end else if (clk_en) begin
			lane6_idle_auto        <= l6_idlert_r[`RLCR_IR_IDLE_AUTO]; // [RL7]
			// auto mode lets signal detect drive muting; manual forces it
			lane6_output_muted     <= !l6_idlert_r[`RLCR_IR_IDLE_AUTO] &&
			                          l6_idlert_r[`RLCR_IR_IDLE_SEL]; // [RL7] [RL8]
			lane6_signal_detect_en <= l6_idlert_r[`RLCR_IR_IDLE_AUTO]; // [RL8]
			lane6_rate_auto        <= l6_idlert_r[`RLCR_IR_RATE_AUTO]; // [RL9]
			lane6_rate_high        <= !l6_idlert_r[`RLCR_IR_RATE_AUTO] &&
			                          (l6_idlert_r[`RLCR_IR_RATE_SEL] ==
			                           rlcr_pkg::RLCR_RATE_HIGH); // [RL9] [RL10]
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			lane6_eq_enable        <= 1'b1;
			lane6_gain_stage_field <= 2'h0;
			lane6_boost_step_field <= 3'h0;
			lane6_eq_level_valid   <= 1'b1;
			lane6_eq_level_index   <= 5'h00;
			lane6_swing_field      <= `RLCR_SW_600;
			lane6_swing_valid      <= 1'b1;
		end else if (clk_en) begin
			lane6_eq_enable        <= l6_eq_r[`RLCR_EQ_EN_BIT]; // [RL11]
			lane6_gain_stage_field <= gain_stage_field; // [RL11]
			lane6_boost_step_field <= boost_step_field; // [RL11]
			// only stages 0..2 exist: 3 x 8 = 24 levels
			lane6_eq_level_valid   <= (gain_stage_field <= `RLCR_EQ_GST_MAX); // [RL12]
			lane6_eq_level_index   <= {gain_stage_field, boost_step_field}; // [RL12]
			lane6_swing_field      <= l6_swing_r[5:0]; // [RL14]
			lane6_swing_valid      <= swing_ok(l6_swing_r[5:0]); // [RL14]
		end
	end

endmodule

//--- sim/rlcr_lane_regs_props.sv
// rlcr_lane_regs_props.sv: port-level checks for the lane register slice.
// assumes one clock domain and the fixed read/write latencies of the slice.
module rlcr_lane_chk #(
	parameter int ADDR_W = 8
) (
	// clock, reset, bus
	input wire logic              clock,
	input wire logic              nrst,
	input wire logic              clk_en,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic              reg_wr,
	input wire logic [7:0]        reg_wdata,
	input wire logic              reg_rd,
	input wire logic [7:0]        reg_rdata,
	input wire logic              reg_hit,
	// lane 5
	input wire logic              lane5_deemphasis_style,
	input wire logic [6:0]        lane5_deemphasis_level,
	input wire logic              lane5_deemph_reserved,
	input wire logic [1:0]        lane5_idle_deassert_th,
	input wire logic [1:0]        lane5_idle_assert_th,
	// lane 6
	input wire logic              lane6_idle_auto,
	input wire logic              lane6_output_muted,
	input wire logic              lane6_signal_detect_en,
	input wire logic              lane6_rate_auto,
	input wire logic              lane6_rate_high,
	input wire logic              lane6_eq_enable,
	input wire logic [1:0]        lane6_gain_stage_field,
	input wire logic [2:0]        lane6_boost_step_field,
	input wire logic              lane6_eq_level_valid,
	input wire logic [4:0]        lane6_eq_level_index,
	input wire logic [5:0]        lane6_swing_field,
	input wire logic              lane6_swing_valid
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] wd1_r;
	logic [7:0] wd2_r;

	// ==========================================
	// write data history, free running so it lines up with the two-edge latency
	always_ff @(posedge clock) begin
		wd1_r <= reg_wdata;
		wd2_r <= wd1_r;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_wr(a);
		clk_en && reg_wr && reg_addr == a ##1 clk_en;
	endsequence

	// ==========================================
	// assertions
	chk_deemph_follow: assert property (
		s_wr(8'h35) |=> {lane5_deemphasis_style, lane5_deemphasis_level} == wd2_r)
		else $error("de-emphasis outputs do not follow write");
	chk_deemph_rsvd: assert property (
		lane5_deemph_reserved == ({lane5_deemphasis_style, lane5_deemphasis_level} == 8'hC0))
		else $error("reserved de-emphasis flag wrong");
	chk_thresh_follow: assert property (
		s_wr(8'h36) |=> {lane5_idle_deassert_th, lane5_idle_assert_th} == wd2_r[3:0])
		else $error("idle threshold outputs do not follow write");
	chk_idle_mode: assert property (
		s_wr(8'h39) |=> {lane6_idle_auto, lane6_output_muted, lane6_signal_detect_en}
			== {wd2_r[5], !wd2_r[5] && wd2_r[4], wd2_r[5]})
		else $error("idle control outputs wrong");
	chk_rate_mode: assert property (
		s_wr(8'h39) |=> {lane6_rate_auto, lane6_rate_high} == {wd2_r[1], !wd2_r[1] && wd2_r[0]})
		else $error("rate control outputs wrong");
	chk_eq_follow: assert property (
		s_wr(8'h3A) |=> {lane6_eq_enable, lane6_gain_stage_field, lane6_boost_step_field}
			== wd2_r[5:0])
		else $error("equalizer outputs do not follow write");
	chk_eq_levels: assert property (
		lane6_eq_level_valid == (lane6_gain_stage_field <= 2'h2)
			&& lane6_eq_level_index == {lane6_gain_stage_field, lane6_boost_step_field})
		else $error("equalizer level index wrong");
	chk_swing_follow: assert property (
		s_wr(8'h3B) |=> lane6_swing_field == wd2_r[5:0]
			&& lane6_swing_valid == (wd2_r[5:0] inside {6'h03, 6'h07, 6'h0F, 6'h1F, 6'h3F}))
		else $error("swing outputs wrong");
	chk_swing_readonly: assert property (
		clk_en && reg_rd && reg_addr == 8'h3B |=> reg_hit && reg_rdata[7:6] == 2'h0)
		else $error("swing read back wrong");

	cover property (s_wr(8'h3B));
	cover property (lane5_deemph_reserved);
	cover property (lane6_output_muted);
	cover property (!lane6_eq_level_valid);
endmodule

bind rlcr_lane_regs rlcr_lane_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- sim/rlcr_host_model.sv
// rlcr_host_model.sv: management host issuing single-byte register accesses.
// assumes the slice's fixed one-edge read latency; no handshake exists.
module rlcr_host_model (
	// clock and read answer
	input  wire logic       clock,
	input  wire logic [7:0] reg_rdata,
	input  wire logic       reg_hit,
	// request
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic      [7:0] reg_wdata,
	output logic            reg_rd
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end

	// callers pass zero in reserved bits except when a refusal is meant
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		// released data does not keep its last value
		reg_wdata <= ~d;
	endtask

	task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic h);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		// answer is registered at the taking edge; pick it up at the next one
		@(posedge clock);
		d = reg_rdata;
		h = reg_hit;
	endtask
endmodule

//--- sim/repeater_lane_config_regs_bench.sv
// repeater_lane_config_regs_bench.sv: directed register and strap tests.
// assumes the host model drives the bus; straps and enable driven here.
module repeater_lane_config_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SWC [6] = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h05};
	localparam logic [7:0] DEC [6] = '{8'h01, 8'h38, 8'h88, 8'h90, 8'hA0, 8'hC0};
	localparam logic [7:0] IRC [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h01, 8'h02, 8'h03};
	localparam logic [7:0] EQC [4] = '{8'h20, 8'h2A, 8'h3F, 8'h17};
	// strap tables: {expected code, first pin, second pin}, F meaning float
	localparam logic [15:0] DTAB [9] = '{16'h0100, 16'h3801, 16'h880F, 16'h9010, 16'hA01F,
		16'h90F0, 16'hA0F1, 16'hA011, 16'hC0FF};
	localparam logic [15:0] ETAB [9] = '{16'h20FF, 16'h2A11, 16'h3000, 16'h310F, 16'h3801,
		16'h341F, 16'h3510, 16'h3AF0, 16'h3CF1};
	logic clock, nrst, clk_en, strap_mode, reg_wr, reg_rd, reg_hit;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	rlcr_pkg::rlcr_pin_e deemph_strap_hi, deemph_strap_lo, equalizer_strap_a, equalizer_strap_b;
	logic lane5_deemphasis_style, lane5_deemph_reserved, lane6_idle_auto, lane6_output_muted;
	logic lane6_signal_detect_en, lane6_rate_auto, lane6_rate_high, lane6_eq_enable;
	logic lane6_eq_level_valid, lane6_swing_valid;
	logic [6:0] lane5_deemphasis_level;
	logic [1:0] lane5_idle_deassert_th, lane5_idle_assert_th, lane6_gain_stage_field;
	logic [2:0] lane6_boost_step_field;
	logic [4:0] lane6_eq_level_index;
	logic [5:0] lane6_swing_field;
	int errors = 0;
	int samples_checked = 0;

	rlcr_lane_regs u_dut (.*);
	rlcr_host_model u_host (.*);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// ==========================================
	// helpers
	function automatic rlcr_pkg::rlcr_pin_e pin(input logic [3:0] n);
		return (n == 4'h0) ? rlcr_pkg::RLCR_PIN_LOW :
			(n == 4'h1) ? rlcr_pkg::RLCR_PIN_HIGH : rlcr_pkg::RLCR_PIN_FLOAT;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hexp);
		logic [7:0] d;
		logic h;
		u_host.read_reg(a, d, h);
		chk(d, exp);
		chk({7'h0, h}, {7'h0, hexp});
	endtask

	task automatic summarize;
		$display("checked %0d values, %0d wrong", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (50000) @(posedge clock);
		errors++;
		summarize();
	end

	// ==========================================
	// main sequence
	initial begin
		nrst = 1'b0;
		clk_en = 1'b1;
		strap_mode = 1'b0;
		deemph_strap_hi = rlcr_pkg::RLCR_PIN_LOW;
		deemph_strap_lo = rlcr_pkg::RLCR_PIN_LOW;
		equalizer_strap_a = rlcr_pkg::RLCR_PIN_LOW;
		equalizer_strap_b = rlcr_pkg::RLCR_PIN_LOW;
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		rd(8'h35, 8'h03, 1'b1);
		rd(8'h36, 8'h00, 1'b1);
		rd(8'h39, 8'h00, 1'b1);
		rd(8'h3A, 8'h20, 1'b1);
		rd(8'h3B, 8'h03, 1'b1);
		rd(8'h37, 8'h00, 1'b0);
		chk({1'b0, lane6_eq_enable, lane6_swing_field}, 8'h43);
		foreach (SWC[i]) begin
			u_host.write_reg(8'h3B, SWC[i]);
			rd(8'h3B, SWC[i], 1'b1);
			chk({1'b0, lane6_swing_valid, lane6_swing_field},
				{1'b0, SWC[i] != 8'h05, SWC[i][5:0]});
		end
		u_host.write_reg(8'h3B, 8'hFF);
		rd(8'h3B, 8'h3F, 1'b1);
		// a write with the enable low is not taken
		clk_en <= 1'b0;
		u_host.write_reg(8'h3B, 8'h07);
		clk_en <= 1'b1;
		rd(8'h3B, 8'h3F, 1'b1);
		foreach (DEC[i]) begin
			u_host.write_reg(8'h35, DEC[i]);
			rd(8'h35, DEC[i], 1'b1);
			chk({lane5_deemphasis_style, lane5_deemphasis_level}, DEC[i]);
			chk({7'h0, lane5_deemph_reserved}, {7'h0, DEC[i] == 8'hC0});
		end
		for (int i = 0; i < 16; i++) begin
			u_host.write_reg(8'h36, 8'(i));
			rd(8'h36, 8'(i), 1'b1);
			chk({4'h0, lane5_idle_deassert_th, lane5_idle_assert_th}, 8'(i));
		end
		u_host.write_reg(8'h36, 8'hF3);
		rd(8'h36, 8'h03, 1'b1);
		foreach (IRC[i]) begin
			u_host.write_reg(8'h39, IRC[i]);
			// outputs follow two edges after the write, so look after the read
			rd(8'h39, IRC[i], 1'b1);
			chk({3'h0, lane6_idle_auto, lane6_output_muted, lane6_signal_detect_en,
				lane6_rate_auto, lane6_rate_high}, {3'h0, IRC[i][5], !IRC[i][5] && IRC[i][4],
				IRC[i][5], IRC[i][1], !IRC[i][1] && IRC[i][0]});
		end
		u_host.write_reg(8'h39, 8'hFF);
		rd(8'h39, 8'h33, 1'b1);
		foreach (EQC[i]) begin
			u_host.write_reg(8'h3A, EQC[i]);
			rd(8'h3A, EQC[i], 1'b1);
			chk({2'h0, lane6_eq_enable, lane6_gain_stage_field, lane6_boost_step_field},
				EQC[i]);
			chk({2'h0, lane6_eq_level_valid, lane6_eq_level_index},
				{2'h0, EQC[i][4:3] != 2'h3, EQC[i][4:0]});
		end
		u_host.write_reg(8'h3A, 8'hFF);
		rd(8'h3A, 8'h3F, 1'b1);
		// straps load on the synchronised rising edge of the mode input
		for (int i = 0; i < 9; i++) begin
			deemph_strap_hi <= pin(DTAB[i][7:4]);
			deemph_strap_lo <= pin(DTAB[i][3:0]);
			equalizer_strap_a <= pin(ETAB[i][7:4]);
			equalizer_strap_b <= pin(ETAB[i][3:0]);
			repeat (4) @(posedge clock);
			strap_mode <= 1'b1;
			repeat (8) @(posedge clock);
			strap_mode <= 1'b0;
			rd(8'h35, DTAB[i][15:8], 1'b1);
			rd(8'h3A, ETAB[i][15:8], 1'b1);
		end
		summarize();
	end
endmodule
